// ==== design/arc_pkg.sv ====
// Constants, field layout and types of the converter register front end
// Functional notes
// - Soft reset command restores reset state, except bus handshake, read data and trigger edge registers
// - Start command bit launches one conversion sequence
// - Trigger enable clear: hardware triggers ignored
// - Trigger enable set: selected hardware source launches
// - Source codes: timers 0-2, external code 110
// - Converter clock is master over 2*(divider+1)
// - Warm-up lasts 8*(field+1) converter clock periods
// - Sample-hold lasts field value converter clock periods
// - Ones in enable-set register enable channels
// - Ones in enable-clear register disable channels
// - Channel state register shows each enable bit
// - Done flag reads one only if enabled, complete
// - Channel overrun flags set since last flags read
// - Result ready set by new unread result
// - Global overrun set since last flags read
// - Receive end set once receive count hit zero
// - Buffers full reads one when both counts zero
// - Result bits 9..0 loaded, held until next
// - Ones in interrupt-enable register enable sources
// - Low resolution: 8-bit result, 8-bit transfers
// - Sleep mode: power up, warm, convert, power down
// - Flags read clears all overrun flags
// - Result read clears ready and last done flag
package arc_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_COMMAND = 8'h00;
  localparam logic [7:0] OFS_CONFIG = 8'h04;
  localparam logic [7:0] OFS_CHAN_SET = 8'h10;
  localparam logic [7:0] OFS_CHAN_CLEAR = 8'h14;
  localparam logic [7:0] OFS_CHAN_STATE = 8'h18;
  localparam logic [7:0] OFS_FLAGS = 8'h1C;
  localparam logic [7:0] OFS_RESULT = 8'h20;
  localparam logic [7:0] OFS_IRQ_SET = 8'h24;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h28;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h2C;
  localparam logic [7:0] OFS_RX_COUNT = 8'h50;
  localparam logic [7:0] OFS_RX_NEXT_COUNT = 8'h54;

  // ==========================================================================
  // Field positions and widths
  localparam int CMD_SOFT_RESET_BIT = 0;
  localparam int CMD_START_BIT = 1;
  localparam int CFG_TRIG_EN_BIT = 0;
  localparam int CFG_TRIG_SEL_LSB = 1;
  localparam int CFG_TRIG_SEL_W = 3;
  localparam int CFG_LOW_RES_BIT = 4;
  localparam int CFG_SLEEP_BIT = 5;
  localparam int CFG_DIV_LSB = 8;
  localparam int CFG_DIV_W = 8;
  localparam int CFG_WARM_LSB = 16;
  localparam int CFG_WARM_W = 7;
  localparam int CFG_SH_LSB = 24;
  localparam int CFG_SH_W = 4;
  localparam logic [31:0] CFG_WRITE_MASK = 32'h0F7F_FF3F;
  localparam int NUM_CHAN = 8;
  localparam int FLAG_OVR_LSB = 8;
  localparam int FLAG_READY_BIT = 16;
  localparam int FLAG_GOVR_BIT = 17;
  localparam int FLAG_RECEIVE_END_FLAG_BIT = 18;
  localparam int FLAG_BUFF_BIT = 19;
  localparam int FLAG_W = 20;
  localparam int RESULT_W = 10;
  localparam int COUNT_W = 16;
  localparam int TICK_W = 11;

  // ==========================================================================
  // Reset values and timing
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [7:0] CHAN_RESET = 8'h00;
  localparam logic [19:0] IRQ_MASK_RESET = 20'h0_0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [10:0] WARMUP_MULT = 11'h008;

  // ==========================================================================
  // Trigger source codes
  localparam logic [2:0] TRIG_TIMER0 = 3'h0;
  localparam logic [2:0] TRIG_TIMER1 = 3'h1;
  localparam logic [2:0] TRIG_TIMER2 = 3'h2;
  localparam logic [2:0] TRIG_EXTERNAL = 3'h6;

  typedef enum logic [2:0] {ST_IDLE, ST_WARMUP, ST_PICK, ST_SAMPLE, ST_CONVERT} arc_seq_type;

endpackage

// ==== design/arc_adc_control.sv ====
// Register front end, trigger logic and conversion sequencer of the converter
//
// Local design decisions: the Avalon-MM interface to the registers and the placing of the registers.
module arc_adc_control (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [2:0] timer_wave_output_a,
  input wire logic external_trigger_pin,
  output logic converter_clock,
  output logic cell_power_on,
  output logic cell_start,
  output logic [2:0] cell_channel,
  output logic cell_low_resolution,
  input wire logic cell_done,
  input wire logic [9:0] cell_result,
  output logic dma_request,
  output logic dma_wide_transfer,
  input wire logic dma_ack,
  output logic irq
);

  // ==========================================================================
  // Helper functions
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++)
    begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction

  function automatic logic [2:0] first_set(input logic [7:0] v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 7; i >= 0; i--)
    begin
      if (v[i])
      begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  function automatic logic [7:0] one_hot(input logic [2:0] idx);
    return 8'h01 << idx;
  endfunction

  // ==========================================================================
  // Avalon slave handshake: one wait state per access
  logic ack_reg;
  logic [31:0] readdata_reg;
  logic [31:0] wdata;
  logic [31:0] be_mask;
  logic accept_wr;
  logic capture_rd;
  logic soft_rst;
  logic start_cmd;

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign avs_readdata = readdata_reg;
  assign accept_wr = avs_write & ack_reg;
  assign capture_rd = avs_read & ~ack_reg;
  assign be_mask = lane_mask(avs_byteenable);
  assign wdata = avs_writedata & be_mask;
  assign soft_rst = accept_wr && avs_address == arc_pkg::OFS_COMMAND
    && wdata[arc_pkg::CMD_SOFT_RESET_BIT];
  assign start_cmd = accept_wr && avs_address == arc_pkg::OFS_COMMAND
    && wdata[arc_pkg::CMD_START_BIT];

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ack_reg <= 1'b0;
    end
    else
    begin
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
    end
  end

  // ==========================================================================
  // Configuration, channel enables, interrupt mask
  logic [31:0] cfg_reg;
  logic [7:0] chan_en_reg;
  logic [19:0] imr_reg;
  logic trig_en;
  logic [2:0] trig_sel;
  logic low_res;
  logic sleep_mode;
  logic [7:0] clock_divider_setting;
  logic [6:0] startup;
  logic [3:0] sample_hold_time;

  assign trig_en = cfg_reg[arc_pkg::CFG_TRIG_EN_BIT];
  assign trig_sel = cfg_reg[arc_pkg::CFG_TRIG_SEL_LSB +: arc_pkg::CFG_TRIG_SEL_W];
  assign low_res = cfg_reg[arc_pkg::CFG_LOW_RES_BIT];
  assign sleep_mode = cfg_reg[arc_pkg::CFG_SLEEP_BIT];
  assign clock_divider_setting = cfg_reg[arc_pkg::CFG_DIV_LSB +: arc_pkg::CFG_DIV_W];
  assign startup = cfg_reg[arc_pkg::CFG_WARM_LSB +: arc_pkg::CFG_WARM_W];
  assign sample_hold_time = cfg_reg[arc_pkg::CFG_SH_LSB +: arc_pkg::CFG_SH_W];

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cfg_reg <= arc_pkg::CFG_RESET;
    end
    else if (soft_rst)
    begin
      cfg_reg <= arc_pkg::CFG_RESET;
    end
    else if (accept_wr && avs_address == arc_pkg::OFS_CONFIG)
    begin
      cfg_reg <= (cfg_reg & ~(be_mask & arc_pkg::CFG_WRITE_MASK))
        | (wdata & arc_pkg::CFG_WRITE_MASK);
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      chan_en_reg <= arc_pkg::CHAN_RESET;
    end
    else if (soft_rst)
    begin
      chan_en_reg <= arc_pkg::CHAN_RESET;
    end
    else if (accept_wr && avs_address == arc_pkg::OFS_CHAN_SET)
    begin
      chan_en_reg <= chan_en_reg | wdata[7:0];
    end
    else if (accept_wr && avs_address == arc_pkg::OFS_CHAN_CLEAR)
    begin
      chan_en_reg <= chan_en_reg & ~wdata[7:0];
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      imr_reg <= arc_pkg::IRQ_MASK_RESET;
    end
    else if (soft_rst)
    begin
      imr_reg <= arc_pkg::IRQ_MASK_RESET;
    end
    else if (accept_wr && avs_address == arc_pkg::OFS_IRQ_SET)
    begin
      imr_reg <= imr_reg | wdata[19:0];
    end
    else if (accept_wr && avs_address == arc_pkg::OFS_IRQ_CLEAR)
    begin
      imr_reg <= imr_reg & ~wdata[19:0];
    end
  end

  // ==========================================================================
  // Hardware trigger selection and rising edge
  logic trig_level;
  logic trig_prev_reg;
  logic hw_edge;
  logic start_req;

  always_comb
  begin
    case (trig_sel)
      arc_pkg::TRIG_TIMER0: trig_level = timer_wave_output_a[0];
      arc_pkg::TRIG_TIMER1: trig_level = timer_wave_output_a[1];
      arc_pkg::TRIG_TIMER2: trig_level = timer_wave_output_a[2];
      arc_pkg::TRIG_EXTERNAL: trig_level = external_trigger_pin;
      default: trig_level = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      trig_prev_reg <= 1'b0;
    end
    else
    begin
      trig_prev_reg <= trig_level;
    end
  end

  assign hw_edge = trig_en & trig_level & ~trig_prev_reg;
  assign start_req = (start_cmd | hw_edge) & ~soft_rst;

  // ==========================================================================
  // Converter clock divider
  logic [7:0] div_cnt_reg;
  logic conv_clk_reg;
  logic tick;

  assign tick = (div_cnt_reg >= clock_divider_setting) & ~conv_clk_reg;
  assign converter_clock = conv_clk_reg;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      div_cnt_reg <= 8'h00;
      conv_clk_reg <= 1'b0;
    end
    else if (soft_rst)
    begin
      div_cnt_reg <= 8'h00;
      conv_clk_reg <= 1'b0;
    end
    else if (div_cnt_reg >= clock_divider_setting)
    begin
      div_cnt_reg <= 8'h00;
      conv_clk_reg <= ~conv_clk_reg;
    end
    else
    begin
      div_cnt_reg <= div_cnt_reg + 8'h01;
    end
  end

  // ==========================================================================
  // Conversion sequencer
  arc_pkg::arc_seq_type state_reg;
  logic [7:0] pending_reg;
  logic [2:0] chan_reg;
  logic [10:0] tick_cnt_reg;
  logic [10:0] warm_target;
  logic warm_reg;
  logic power_reg;
  logic start_pulse_reg;
  logic conv_done;

  assign warm_target = arc_pkg::WARMUP_MULT * (11'(startup) + 11'h001);
  assign conv_done = (state_reg == arc_pkg::ST_CONVERT) & cell_done & ~soft_rst;
  assign cell_power_on = power_reg;
  assign cell_start = start_pulse_reg;
  assign cell_channel = chan_reg;
  assign cell_low_resolution = low_res;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_reg <= arc_pkg::ST_IDLE;
      pending_reg <= 8'h00;
      chan_reg <= 3'h0;
      tick_cnt_reg <= 11'h000;
      warm_reg <= 1'b0;
      power_reg <= 1'b0;
      start_pulse_reg <= 1'b0;
    end
    else if (soft_rst)
    begin
      state_reg <= arc_pkg::ST_IDLE;
      pending_reg <= 8'h00;
      chan_reg <= 3'h0;
      tick_cnt_reg <= 11'h000;
      warm_reg <= 1'b0;
      power_reg <= 1'b0;
      start_pulse_reg <= 1'b0;
    end
    else
    begin
      start_pulse_reg <= 1'b0;
      case (state_reg)
        arc_pkg::ST_IDLE:
        begin
          if (!sleep_mode && !warm_reg)
          begin
            power_reg <= 1'b0;
          end
          if (start_req && chan_en_reg != 8'h00)
          begin
            pending_reg <= chan_en_reg;
            power_reg <= 1'b1;
            tick_cnt_reg <= 11'h000;
            state_reg <= warm_reg ? arc_pkg::ST_PICK : arc_pkg::ST_WARMUP;
          end
        end
        arc_pkg::ST_WARMUP:
        begin
          if (tick)
          begin
            if (tick_cnt_reg == warm_target - 11'h001)
            begin
              warm_reg <= 1'b1;
              state_reg <= arc_pkg::ST_PICK;
            end
            else
            begin
              tick_cnt_reg <= tick_cnt_reg + 11'h001;
            end
          end
        end
        arc_pkg::ST_PICK:
        begin
          tick_cnt_reg <= 11'h000;
          if (pending_reg == 8'h00)
          begin
            state_reg <= arc_pkg::ST_IDLE;
            if (sleep_mode)
            begin
              power_reg <= 1'b0;
              warm_reg <= 1'b0;
            end
          end
          else
          begin
            chan_reg <= first_set(pending_reg);
            state_reg <= arc_pkg::ST_SAMPLE;
          end
        end
        arc_pkg::ST_SAMPLE:
        begin
          if (tick_cnt_reg >= 11'(sample_hold_time))
          begin
            start_pulse_reg <= 1'b1;
            state_reg <= arc_pkg::ST_CONVERT;
          end
          else if (tick)
          begin
            tick_cnt_reg <= tick_cnt_reg + 11'h001;
          end
        end
        arc_pkg::ST_CONVERT:
        begin
          if (cell_done)
          begin
            pending_reg <= pending_reg & ~one_hot(chan_reg);
            state_reg <= arc_pkg::ST_PICK;
          end
        end
        default:
        begin
          state_reg <= arc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Result and status flags
  logic [7:0] eoc_reg;
  logic [7:0] ovre_reg;
  logic result_ready_flag_reg;
  logic global_overrun_flag_reg;
  logic [9:0] latest_reg;
  logic [2:0] last_chan_reg;
  logic rd_flags;
  logic rd_result;
  logic [9:0] new_result;

  // Read clears at the capture edge, so a later event is not lost
  assign rd_flags = capture_rd && avs_address == arc_pkg::OFS_FLAGS;
  assign rd_result = capture_rd && avs_address == arc_pkg::OFS_RESULT;
  assign new_result = low_res ? {2'b00, cell_result[7:0]} : cell_result;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      eoc_reg <= 8'h00;
      ovre_reg <= 8'h00;
      result_ready_flag_reg <= 1'b0;
      global_overrun_flag_reg <= 1'b0;
      latest_reg <= 10'h000;
      last_chan_reg <= 3'h0;
    end
    else if (soft_rst)
    begin
      eoc_reg <= 8'h00;
      ovre_reg <= 8'h00;
      result_ready_flag_reg <= 1'b0;
      global_overrun_flag_reg <= 1'b0;
      latest_reg <= 10'h000;
      last_chan_reg <= 3'h0;
    end
    else
    begin
      // Sets are applied after clears so a same-cycle event wins
      eoc_reg <= (eoc_reg & ~(rd_result ? one_hot(last_chan_reg) : 8'h00))
        | (conv_done ? one_hot(chan_reg) & chan_en_reg : 8'h00);
      ovre_reg <= (rd_flags ? 8'h00 : ovre_reg)
        | (conv_done ? one_hot(chan_reg) & eoc_reg : 8'h00);
      result_ready_flag_reg <= (result_ready_flag_reg & ~rd_result) | conv_done;
      global_overrun_flag_reg <= (global_overrun_flag_reg & ~rd_flags) | (conv_done & result_ready_flag_reg);
      if (conv_done)
      begin
        latest_reg <= new_result;
        last_chan_reg <= chan_reg;
      end
    end
  end

  // ==========================================================================
  // Receive counters of the DMA channel
  logic [15:0] rcr_reg;
  logic [15:0] rncr_reg;
  logic receive_end_flag_reg;
  logic dma_req_reg;
  logic receive_buffers_full_flag;

  assign receive_buffers_full_flag = (rcr_reg == 16'h0000) & (rncr_reg == 16'h0000);
  assign dma_request = dma_req_reg;
  assign dma_wide_transfer = ~low_res;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rcr_reg <= arc_pkg::COUNT_RESET;
      rncr_reg <= arc_pkg::COUNT_RESET;
      receive_end_flag_reg <= 1'b1;
      dma_req_reg <= 1'b0;
    end
    else if (soft_rst)
    begin
      rcr_reg <= arc_pkg::COUNT_RESET;
      rncr_reg <= arc_pkg::COUNT_RESET;
      receive_end_flag_reg <= 1'b1;
      dma_req_reg <= 1'b0;
    end
    else
    begin
      dma_req_reg <= conv_done & (rcr_reg != 16'h0000);
      if (accept_wr && avs_address == arc_pkg::OFS_RX_COUNT)
      begin
        rcr_reg <= (rcr_reg & ~be_mask[15:0]) | wdata[15:0];
        receive_end_flag_reg <= 1'b0;
      end
      else if (accept_wr && avs_address == arc_pkg::OFS_RX_NEXT_COUNT)
      begin
        rncr_reg <= (rncr_reg & ~be_mask[15:0]) | wdata[15:0];
        receive_end_flag_reg <= 1'b0;
      end
      else if (dma_ack && rcr_reg != 16'h0000)
      begin
        if (rcr_reg == 16'h0001)
        begin
          receive_end_flag_reg <= 1'b1;
          rcr_reg <= rncr_reg;
          rncr_reg <= 16'h0000;
        end
        else
        begin
          rcr_reg <= rcr_reg - 16'h0001;
        end
      end
    end
  end

  // ==========================================================================
  // Status vector, interrupt, read data
  logic [19:0] flag_vec;
  logic irq_reg;
  logic [31:0] read_mux;

  assign flag_vec = {receive_buffers_full_flag, receive_end_flag_reg, global_overrun_flag_reg, result_ready_flag_reg, ovre_reg,
    eoc_reg & chan_en_reg};
  assign irq = irq_reg;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      irq_reg <= 1'b0;
    end
    else if (soft_rst)
    begin
      irq_reg <= 1'b0;
    end
    else
    begin
      irq_reg <= |(flag_vec & imr_reg);
    end
  end

  always_comb
  begin
    case (avs_address)
      arc_pkg::OFS_CONFIG: read_mux = cfg_reg;
      arc_pkg::OFS_CHAN_STATE: read_mux = {24'h00_0000, chan_en_reg};
      arc_pkg::OFS_FLAGS: read_mux = {12'h000, flag_vec};
      arc_pkg::OFS_RESULT: read_mux = {22'h00_0000, latest_reg};
      arc_pkg::OFS_IRQ_MASK: read_mux = {12'h000, imr_reg};
      arc_pkg::OFS_RX_COUNT: read_mux = {16'h0000, rcr_reg};
      arc_pkg::OFS_RX_NEXT_COUNT: read_mux = {16'h0000, rncr_reg};
      default: read_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      readdata_reg <= 32'h0000_0000;
    end
    else if (capture_rd)
    begin
      readdata_reg <= read_mux;
    end
  end

  // ==========================================================================
  // Assertions
  soft_reset_a: assert property (@(posedge clk) disable iff (reset)
    soft_rst |=> chan_en_reg == 8'h00 && cfg_reg == 32'h0000_0000
      && state_reg == arc_pkg::ST_IDLE && !result_ready_flag_reg)
    else $error("soft reset did not restore reset state");

  sw_start_a: assert property (@(posedge clk) disable iff (reset)
    state_reg == arc_pkg::ST_IDLE && start_cmd && !soft_rst && chan_en_reg != 8'h00
      |=> state_reg != arc_pkg::ST_IDLE && power_reg)
    else $error("start command did not launch a sequence");

  hw_ignore_a: assert property (@(posedge clk) disable iff (reset)
    state_reg == arc_pkg::ST_IDLE && !trig_en && !start_cmd
      |=> state_reg == arc_pkg::ST_IDLE)
    else $error("sequence launched with hardware triggers disabled");

  hw_accept_a: assert property (@(posedge clk) disable iff (reset)
    state_reg == arc_pkg::ST_IDLE && trig_en && trig_level && !trig_prev_reg
      && !soft_rst && chan_en_reg != 8'h00 |=> state_reg != arc_pkg::ST_IDLE)
    else $error("hardware trigger edge not accepted");

  clock_div_a: assert property (@(posedge clk) disable iff (reset)
    $rose(converter_clock) && $stable(clock_divider_setting) && !$past(soft_rst)
      |-> $past(div_cnt_reg) == clock_divider_setting)
    else $error("converter clock edge off divider count");

  warmup_len_a: assert property (@(posedge clk) disable iff (reset)
    $rose(warm_reg) |-> $past(tick_cnt_reg) == warm_target - 11'h001 && $past(tick))
    else $error("warm-up ended at wrong tick count");

  sample_len_a: assert property (@(posedge clk) disable iff (reset)
    $rose(cell_start) |-> $past(tick_cnt_reg) >= 11'(sample_hold_time)
      && $past(state_reg) == arc_pkg::ST_SAMPLE)
    else $error("conversion started before sample-hold elapsed");

  chan_set_a: assert property (@(posedge clk) disable iff (reset)
    accept_wr && avs_address == arc_pkg::OFS_CHAN_SET && !soft_rst
      |=> chan_en_reg == ($past(chan_en_reg) | $past(wdata[7:0])))
    else $error("channel enable write mismatch");

  result_load_a: assert property (@(posedge clk) disable iff (reset)
    conv_done |=> result_ready_flag_reg && latest_reg == $past(new_result)
      && $past(chan_en_reg[chan_reg]) == eoc_reg[last_chan_reg])
    else $error("result or ready flag not loaded");

  ovr_clear_a: assert property (@(posedge clk) disable iff (reset)
    rd_flags && !conv_done && !soft_rst |=> ovre_reg == 8'h00 && !global_overrun_flag_reg)
    else $error("flags read did not clear overruns");

  result_clear_a: assert property (@(posedge clk) disable iff (reset)
    rd_result && !conv_done && !soft_rst |=> !result_ready_flag_reg && !eoc_reg[last_chan_reg])
    else $error("result read did not clear ready flags");

  irq_off_a: assert property (@(posedge clk) disable iff (reset)
    (flag_vec & imr_reg) == 20'h0_0000 ##1 (flag_vec & imr_reg) == 20'h0_0000 |-> !irq)
    else $error("interrupt high with no enabled flag");

endmodule

// ==== verif/arc_cell_model.sv ====
// Behavioural analog cell answering each start with one result
module arc_cell_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic cell_start,
  input wire logic [2:0] cell_channel,
  output logic cell_done,
  output logic [9:0] cell_result
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] wait_reg;
  // ==========================================
  // Conversion delay, result idles toggling
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wait_reg <= 2'h0;
      cell_done <= 1'b0;
      cell_result <= 10'h3FF;
    end
    else
    begin
      wait_reg <= cell_start ? 2'h3 : wait_reg - (wait_reg != 2'h0);
      cell_done <= wait_reg == 2'h1;
      cell_result <= (wait_reg == 2'h1) ? {7'h54, cell_channel} : ~cell_result;
    end
  end
endmodule

// ==== verif/test_adc_register_control.sv ====
// Self-checking bench of the converter register front end
module test_adc_register_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset, avs_read, avs_write, avs_waitrequest, ext_pin;
  logic cell_done, cell_start, irq, dack, dreq, wide, lowr, pwr, cclk;
  logic [2:0] tmr;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [2:0] cell_channel;
  logic [9:0] cell_result;
  int num_errors, total_checks, starts, n, reqs;
  arc_adc_control u_arc_adc_control (.clk(clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .timer_wave_output_a(tmr), .external_trigger_pin(ext_pin), .converter_clock(cclk),
    .cell_power_on(pwr), .cell_start(cell_start), .cell_channel(cell_channel),
    .cell_low_resolution(lowr), .cell_done(cell_done), .cell_result(cell_result),
    .dma_request(dreq), .dma_wide_transfer(wide), .dma_ack(dack), .irq(irq));
  arc_cell_model u_arc_cell_model (.clk(clk), .reset(reset), .cell_start(cell_start),
    .cell_channel(cell_channel), .cell_done(cell_done), .cell_result(cell_result));
  // ==========================================
  // Clock, tasks and scenarios
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (cell_start === 1'b1) starts++;
  always @(posedge clk) if (dreq === 1'b1) reqs++;
  task print_verdict;
    if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do
    begin
      @(posedge clk);
    end
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask
  task conv;
    int i;
    for (i = 0; i < 500 && cell_done !== 1'b1; i++) @(posedge clk);
    repeat (3) @(posedge clk);
  endtask
  task t_soft;
    rdchk(8'h1C, 32'h000C_0000);
    bus(1'b1, 8'h04, 32'h0F7F_FF3F);
    rdchk(8'h04, 32'h0F7F_FF3F);
    bus(1'b1, 8'h10, 32'h0000_00FF);
    bus(1'b1, 8'h00, 32'h0000_0001);
    rdchk(8'h04, 32'h0000_0000);
    rdchk(8'h18, 32'h0000_0000);
  endtask
  task t_chan;
    logic c;
    bus(1'b1, 8'h10, 32'h0000_0005);
    bus(1'b1, 8'h14, 32'h0000_0001);
    rdchk(8'h18, 32'h0000_0004);
    c = cclk;
    @(posedge clk);
    chk({31'h0, cclk}, {31'h0, ~c});
  endtask
  task t_start;
    bus(1'b1, 8'h24, 32'h0001_0000);
    bus(1'b1, 8'h00, 32'h0000_0002);
    conv;
    chk({31'h0, irq}, 32'h0000_0001);
    rdchk(8'h1C, 32'h000D_0004);
    rdchk(8'h20, 32'h0000_02A2);
    rdchk(8'h1C, 32'h000C_0000);
    chk({31'h0, irq}, 32'h0000_0000);
  endtask
  task t_overrun;
    bus(1'b1, 8'h00, 32'h0000_0002);
    conv;
    bus(1'b1, 8'h00, 32'h0000_0002);
    conv;
    rdchk(8'h1C, 32'h000F_0404);
    rdchk(8'h1C, 32'h000D_0004);
  endtask
  task t_trig;
    n = starts;
    bus(1'b1, 8'h04, 32'h0000_000C);
    @(posedge clk) ext_pin <= 1'b1;
    @(posedge clk) ext_pin <= 1'b0;
    conv;
    chk(starts, n);
    bus(1'b1, 8'h04, 32'h0000_000D);
    @(posedge clk) ext_pin <= 1'b1;
    @(posedge clk) ext_pin <= 1'b0;
    conv;
    chk(starts, n + 1);
    bus(1'b1, 8'h04, 32'h0000_0003);
    @(posedge clk) tmr <= 3'h2;
    @(posedge clk) tmr <= 3'h0;
    conv;
    chk(starts, n + 2);
  endtask
  task t_dma;
    n = reqs;
    bus(1'b1, 8'h04, 32'h0000_0010);
    bus(1'b1, 8'h50, 32'h0000_0001);
    bus(1'b0, 8'h1C, 32'h0000_0000);
    chk(rd & 32'h000C_0000, 32'h0000_0000);
    bus(1'b1, 8'h00, 32'h0000_0002);
    conv;
    chk(reqs, n + 1);
    chk({30'h0, wide, lowr}, 32'h0000_0001);
    rdchk(8'h20, 32'h0000_00A2);
    @(posedge clk) dack <= 1'b1;
    @(posedge clk) dack <= 1'b0;
    bus(1'b0, 8'h1C, 32'h0000_0000);
    chk(rd & 32'h000C_0000, 32'h000C_0000);
  endtask
  task t_sleep;
    n = starts;
    bus(1'b1, 8'h04, 32'h0000_0020);
    bus(1'b1, 8'h00, 32'h0000_0002);
    conv;
    chk({31'h0, pwr}, 32'h0000_0000);
    bus(1'b1, 8'h00, 32'h0000_0002);
    @(posedge clk);
    chk({31'h0, pwr}, 32'h0000_0001);
    conv;
    chk(starts, n + 2);
  endtask
  initial
  begin
    reset = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0000_0000;
    ext_pin = 1'b0;
    dack = 1'b0;
    tmr = 3'h0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    t_soft;
    t_chan;
    t_start;
    t_overrun;
    t_trig;
    t_dma;
    t_sleep;
    print_verdict;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    print_verdict;
  end
endmodule
